// ---- verilog/i2c_eeprom_slave.v ----
// i2c target logic of a 64 kbit serial eeprom with 32-byte page write buffer
//
// Notes on behaviour
// - sda edges while scl high: start, stop
// - sda changes only while scl is low
// - sample on scl rise, drive after fall
// - array is 8192 bytes, 13-bit address
// - upper four bits match device type code
// - next three bits match chip select inputs
// - four-contact variant uses chip select zero
// - address lsb one reads, zero writes
// - transmitter releases sda in ninth clock
// - receiver acks low, nack leaves high
// - ack address, memory address, data bytes
// - stop after data starts busy, no acks
// - buffer up to 32 bytes from address
// - page fixed, offset wraps, later overwrite
// - all buffered bytes programmed after stop
// - erased array reads all ones
// - read address sends byte at current address
// - nack then stop ends read, idle
// - master ack requests next read byte
// - read address increments, wraps to zero
`timescale 1ns/1ps
`include "eeprom_map.vh"
module i2c_eeprom_slave #(
  parameter integer               TIMER_W      = `TIMER_W,
  parameter [TIMER_W-1:0]         WRITE_CYCLES = `WR_CYCLES
) (
  input  wire clk,
  input  wire reset,
  input  wire scl,
  input  wire sda_in,
  output wire sda_out,
  output reg  sda_oe,
  input  wire chip_select_bit2,
  input  wire chip_select_bit1,
  input  wire chip_select_bit0,
  input  wire four_contact,
  output reg  write_busy
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_ACK  = 6'h04;
  localparam [5:0] S_RX   = 6'h08;
  localparam [5:0] S_TX   = 6'h10;
  localparam [5:0] S_MACK = 6'h20;

  // offset advance that keeps the page bits fixed
  function [`ADDR_W-1:0] page_next;
    input [`ADDR_W-1:0] a;
    begin
      page_next = {a[`ADDR_W-1:`OFF_W], a[`OFF_W-1:0] + 1'b1};
    end
  endfunction

  // open-drain drive for the leading bit of a byte: pull low only for a zero
  function lead_low;
    input [`DATA_W-1:0] d;
    begin
      lead_low = ~d[`DATA_W-1];
    end
  endfunction

  // bit counter advance, shared by the receive and transmit shifters
  function [`BIT_CNT_W-1:0] count_up;
    input [`BIT_CNT_W-1:0] c;
    begin
      count_up = c + 1'b1;
    end
  endfunction

  // target address byte decode: device type code, then chip select bits
  function addr_match;
    input [`DATA_W-1:0] a;
    input [2:0]         cs;
    begin
      addr_match = (a[`TYPE_MSB:`TYPE_LSB] == `DEV_TYPE_CODE)
                   && (a[`CS_MSB:`CS_LSB] == cs);
    end
  endfunction

  // pin synchronisers: first stage is read only by the second
  reg [5:0] pin_meta;
  reg [5:0] pin_sync;
  reg       scl_prev;
  reg       sda_prev;

  // idle-high reset levels keep the release of reset from looking like a start or stop
  always @(posedge clk) begin
    if (reset) begin
      pin_meta <= 6'h03;
      pin_sync <= 6'h03;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      pin_meta <= {four_contact, chip_select_bit2, chip_select_bit1, chip_select_bit0, sda_in, scl};
      pin_sync <= pin_meta;
      scl_prev <= pin_sync[0];
      sda_prev <= pin_sync[1];
    end
  end

  wire       scl_s      = pin_sync[0];
  wire       sda_s      = pin_sync[1];
  wire [2:0] cs_pins    = pin_sync[4:2];
  wire       four_c     = pin_sync[5];
  wire       scl_rise   = scl_s & ~scl_prev;
  wire       scl_fall   = ~scl_s & scl_prev;
  wire       start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
  wire       stop_cond  = scl_s & scl_prev & ~sda_prev & sda_s;

  // open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;

  reg  [5:0]             state;
  reg  [`BIT_CNT_W-1:0]  bit_cnt;
  reg  [`BYTE_CNT_W-1:0] byte_cnt;
  reg  [`DATA_W-1:0]     rx_shift;
  reg  [`DATA_W-1:0]     tx_shift;
  reg                    rw;
  reg                    master_ack;
  reg  [`ADDR_HI_W-1:0]  addr_hi;
  reg  [`ADDR_W-1:0]     cur_addr;
  reg  [`PAGE_BYTES-1:0] byte_valid;
  reg                    have_data;
  reg                    prog_go;
  reg                    buf_we;
  reg  [`OFF_W-1:0]      buf_waddr;
  reg  [`DATA_W-1:0]     buf_wdata;
  wire [`DATA_W-1:0]     array_rdata;

  wire [2:0] cs_expect = four_c ? `CS_FIXED : cs_pins;
  wire       addr_hit  = addr_match(rx_shift, cs_expect)
                         && !write_busy;
  wire       byte_full = (bit_cnt == `BITS_PER_BYTE);

  // bus side sequencer
  always @(posedge clk) begin
    if (reset) begin
      state      <= S_IDLE;
      bit_cnt    <= {`BIT_CNT_W{1'b0}};
      byte_cnt   <= `BC_ADDR_HI;
      rx_shift   <= {`DATA_W{1'b0}};
      tx_shift   <= {`DATA_W{1'b0}};
      rw         <= 1'b0;
      master_ack <= 1'b0;
      addr_hi    <= {`ADDR_HI_W{1'b0}};
      cur_addr   <= {`ADDR_W{1'b0}};
      byte_valid <= {`PAGE_BYTES{1'b0}};
      have_data  <= 1'b0;
      prog_go    <= 1'b0;
      buf_we     <= 1'b0;
      buf_waddr  <= {`OFF_W{1'b0}};
      buf_wdata  <= {`DATA_W{1'b0}};
      sda_oe     <= 1'b0;
    end else begin
      prog_go <= 1'b0;
      buf_we  <= 1'b0;
      if (start_cond) begin
        // a repeated start also lands here; data not yet closed by a stop is dropped
        state     <= S_ADDR;
        bit_cnt   <= {`BIT_CNT_W{1'b0}};
        byte_cnt  <= `BC_ADDR_HI;
        have_data <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (stop_cond) begin
        state     <= S_IDLE;
        prog_go   <= have_data;
        have_data <= 1'b0;
        sda_oe    <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            sda_oe <= 1'b0;
          end
          S_ADDR, S_RX: begin
            if (scl_rise && !byte_full) begin
              rx_shift <= {rx_shift[`DATA_W-2:0], sda_s};
              bit_cnt  <= count_up(bit_cnt);
            end else if (scl_fall && byte_full) begin
              bit_cnt <= {`BIT_CNT_W{1'b0}};
              if (state == S_ADDR) begin
                if (addr_hit) begin
                  rw     <= rx_shift[`RW_BIT];
                  sda_oe <= 1'b1;
                  state  <= S_ACK;
                end else begin
                  // no match or still programming: leave sda released and wait for a start
                  state <= S_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                state  <= S_ACK;
                case (byte_cnt)
                  `BC_ADDR_HI: begin
                    addr_hi  <= rx_shift[`ADDR_HI_MSB:0];
                    byte_cnt <= `BC_ADDR_LO;
                  end
                  `BC_ADDR_LO: begin
                    cur_addr   <= {addr_hi, rx_shift};
                    byte_valid <= {`PAGE_BYTES{1'b0}};
                    byte_cnt   <= `BC_DATA;
                  end
                  default: begin
                    buf_we                          <= 1'b1;
                    buf_waddr                       <= cur_addr[`OFF_W-1:0];
                    buf_wdata                       <= rx_shift;
                    byte_valid[cur_addr[`OFF_W-1:0]] <= 1'b1;
                    cur_addr                        <= page_next(cur_addr);
                    have_data                       <= 1'b1;
                  end
                endcase
              end
            end
          end
          S_ACK: begin
            // our ack stands through the whole ninth clock; on its falling edge sda is released for a write, or set to the first data bit for a read
            if (scl_fall) begin
              if (rw == `RW_READ) begin
                tx_shift <= array_rdata;
                sda_oe   <= lead_low(array_rdata);
                state    <= S_TX;
              end else begin
                sda_oe <= 1'b0;
                state  <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise && !byte_full) begin
              bit_cnt <= count_up(bit_cnt);
            end else if (scl_fall && byte_full) begin
              bit_cnt  <= {`BIT_CNT_W{1'b0}};
              sda_oe   <= 1'b0;
              cur_addr <= cur_addr + 1'b1;
              state    <= S_MACK;
            end else if (scl_fall && bit_cnt != {`BIT_CNT_W{1'b0}}) begin
              tx_shift <= {tx_shift[`DATA_W-2:0], 1'b0};
              sda_oe   <= lead_low({tx_shift[`DATA_W-2:0], 1'b0});
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
              bit_cnt    <= {{(`BIT_CNT_W-1){1'b0}}, 1'b1};
            end else if (scl_fall && bit_cnt != {`BIT_CNT_W{1'b0}}) begin
              bit_cnt <= {`BIT_CNT_W{1'b0}};
              if (master_ack) begin
                tx_shift <= array_rdata;
                sda_oe   <= lead_low(array_rdata);
                state    <= S_TX;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          default: begin
            state  <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // programming engine: copies the valid buffered bytes, then holds busy until the timer ends
  reg  [TIMER_W-1:0]  timer;
  reg  [`COPY_W-1:0]  copy_idx;
  reg                 copy_stage;
  reg  [`OFF_W-1:0]   copy_off;
  reg  [`PAGE_W-1:0]  prog_page;
  wire [TIMER_W-1:0]  next_timer = timer + 1'b1;
  wire [`DATA_W-1:0]  buf_rdata;
  wire                array_we   = copy_stage & byte_valid[copy_off];
  wire                copy_more  = (copy_idx != `COPY_END);

  // the buffer read is registered, so each array write trails copy_idx by one cycle

  always @(posedge clk) begin
    if (reset) begin
      write_busy <= 1'b0;
      timer      <= {TIMER_W{1'b0}};
      copy_idx   <= `COPY_END;
      copy_stage <= 1'b0;
      copy_off   <= {`OFF_W{1'b0}};
      prog_page  <= {`PAGE_W{1'b0}};
    end else begin
      copy_stage <= write_busy && copy_more;
      copy_off   <= copy_idx[`OFF_W-1:0];
      if (prog_go) begin
        write_busy <= 1'b1;
        timer      <= {TIMER_W{1'b0}};
        copy_idx   <= {`COPY_W{1'b0}};
        prog_page  <= cur_addr[`ADDR_W-1:`OFF_W];
      end else if (write_busy) begin
        timer <= next_timer;
        if (next_timer == WRITE_CYCLES) begin
          write_busy <= 1'b0;
        end
        if (copy_more) begin
          copy_idx <= copy_idx + 1'b1;
        end
      end
    end
  end

  byte_memory #(
    .DATA_W (`DATA_W),
    .DEPTH  (`PAGE_BYTES),
    .ADDR_W (`OFF_W),
    .INIT   (`ERASED_BYTE)
  ) page_buffer (
    .clk     (clk),
    .wr_en   (buf_we),
    .wr_addr (buf_waddr),
    .wr_data (buf_wdata),
    .rd_addr (copy_idx[`OFF_W-1:0]),
    .rd_data (buf_rdata)
  );

  // array starts erased; single write port is only used by the copy engine
  byte_memory #(
    .DATA_W (`DATA_W),
    .DEPTH  (`MEM_DEPTH),
    .ADDR_W (`ADDR_W),
    .INIT   (`ERASED_BYTE)
  ) array (
    .clk     (clk),
    .wr_en   (array_we),
    .wr_addr ({prog_page, copy_off}),
    .wr_data (buf_rdata),
    .rd_addr (cur_addr),
    .rd_data (array_rdata)
  );

endmodule

// ---- verilog/eeprom_map.vh ----
// constants shared by the serial eeprom target logic
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH

// array geometry
`define ADDR_W          13
`define MEM_DEPTH       8192
`define DATA_W          8
`define ERASED_BYTE     8'hff

// page write buffer geometry
`define OFF_W           5
`define PAGE_W          8
`define PAGE_BYTES      32
`define COPY_W          6
`define COPY_END        6'h20

// target address byte layout
`define TYPE_MSB        7
`define TYPE_LSB        4
`define CS_MSB          3
`define CS_LSB          1
`define RW_BIT          0
`define RW_READ         1'b1
// arbitrary neutral device-type code, not tied to any real part
`define DEV_TYPE_CODE   4'h5
`define CS_FIXED        3'h0

// memory address byte layout: only the low five bits of the high byte are used
`define ADDR_HI_MSB     4
`define ADDR_HI_W       5

// bit and byte counting
`define BIT_CNT_W       4
`define BITS_PER_BYTE   4'h8
`define BYTE_CNT_W      2
`define BC_ADDR_HI      2'h0
`define BC_ADDR_LO      2'h1
`define BC_DATA         2'h2

// internal programming time
// 4 ms programming time counted in 50 MHz clocks, sized to the timer width
`define WR_CYCLES       18'd200000
`define TIMER_W         18

`endif

// ---- verilog/byte_memory.v ----
// simple dual port byte memory with registered read data
`timescale 1ns/1ps
module byte_memory #(
  parameter integer DATA_W = 8,
  parameter integer DEPTH  = 8192,
  parameter integer ADDR_W = 13,
  parameter [DATA_W-1:0] INIT = 8'hff
) (
  input  wire              clk,
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [DATA_W-1:0] wr_data,
  input  wire [ADDR_W-1:0] rd_addr,
  output reg  [DATA_W-1:0] rd_data
);

  reg [DATA_W-1:0] mem [0:DEPTH-1];
  integer i;

  // contents are non-volatile: reset leaves them alone, power-up shows the erased value
  initial begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      mem[i] = INIT;
    end
  end

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ---- tb/i2c_eeprom_slave_props.sv ----
// assertion checker for the serial eeprom target pins
`timescale 1ns/1ps
module i2c_eeprom_slave_props #(
  parameter integer       TIMER_W      = 18,
  parameter [TIMER_W-1:0] WRITE_CYCLES = 200
) (
  input wire clk,
  input wire reset,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire chip_select_bit2,
  input wire chip_select_bit1,
  input wire chip_select_bit0,
  input wire four_contact,
  input wire write_busy
);
  reg [TIMER_W:0] busy_cnt;
  reg [3:0]       since_stop;
  reg             in_frame;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence start_seen;
    scl && $fell(sda_in);
  endsequence
  sequence quiet_byte;
    (!sda_oe) [*8];
  endsequence
  always @(posedge clk) begin
    if (reset) begin
      busy_cnt <= '0;
      since_stop <= 4'hf;
      in_frame <= 1'b0;
    end else begin
      busy_cnt <= write_busy ? busy_cnt + 1'b1 : '0;
      if (scl && $rose(sda_in)) begin
        since_stop <= 4'h0;
        in_frame <= 1'b0;
      end else begin
        if (since_stop != 4'hf) begin
          since_stop <= since_stop + 4'h1;
        end
        if (scl && $fell(sda_in)) begin
          in_frame <= 1'b1;
        end
      end
    end
  end
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driver value is not low");
  a_oe_after_fall: assert property ($changed(sda_oe) |-> !$past(scl, 2))
    else $error("sda drive changed late in the scl high phase");
  a_stable_high: assert property ((scl && $past(scl) && $past(scl, 2)) |-> $stable(sda_oe))
    else $error("sda drive changed while scl high");
  a_busy_silent: assert property (write_busy |-> !sda_oe)
    else $error("sda pulled during programming");
  a_busy_held: assert property ($rose(write_busy) |=> write_busy [*8])
    else $error("programming ended too soon");
  a_busy_length: assert property ($fell(write_busy) |-> busy_cnt == WRITE_CYCLES)
    else $error("programming length wrong");
  a_busy_after_stop: assert property ($rose(write_busy) |-> since_stop <= 4'h8)
    else $error("programming began without a stop");
  a_drive_in_frame: assert property ($rose(sda_oe) |-> in_frame)
    else $error("sda pulled outside a frame");
  a_start_listens: assert property (start_seen |-> ##6 quiet_byte)
    else $error("sda pulled during address byte");
endmodule
bind i2c_eeprom_slave i2c_eeprom_slave_props #(.TIMER_W(TIMER_W), .WRITE_CYCLES(WRITE_CYCLES)) props_i (
  .clk(clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .chip_select_bit2(chip_select_bit2), .chip_select_bit1(chip_select_bit1),
  .chip_select_bit0(chip_select_bit0), .four_contact(four_contact), .write_busy(write_busy));

// ---- tb/i2c_master_model.sv ----
// bus master model that clocks scl and pulls sda
`timescale 1ns/1ps
module i2c_master_model (
  input  wire clk,
  input  wire sda_wire,
  output reg  scl,
  output reg  sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // long low wait lets the target let go of sda before scl rises
  task automatic start;
    tick(6);
    sda_low = 1'b0;
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop;
    tick(6);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  // data moves only while scl is low and is sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    s = sda_wire;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_out, s);
    ack = ~s;
  endtask
endmodule

// ---- tb/i2c_eeprom_slave_tb.sv ----
// self-checking bench for the serial eeprom target logic
`timescale 1ns/1ps
`include "eeprom_map.vh"
module i2c_eeprom_slave_tb;
  typedef struct packed {
    logic [15:0] wa;
    logic [15:0] ra;
    logic [7:0]  d;
  } row_t;
  localparam logic [2:0] CS = 3'b101;
  logic       clk;
  logic       reset;
  logic [2:0] cs;
  logic       four_contact;
  wire        scl;
  wire        sda_low;
  wire        sda_out;
  wire        sda_oe;
  wire        write_busy;
  wire        sda_wire;
  int         fail_count;
  int         compares;
  int         n;
  logic       k;
  logic [7:0] rx;
  row_t       rows [4];
  assign sda_wire = !sda_low && (sda_oe ? sda_out : 1'b1);
  i2c_master_model i2c_master_model_i (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
  i2c_eeprom_slave #(.WRITE_CYCLES(18'd200)) i2c_eeprom_slave_i (.clk(clk), .reset(reset), .scl(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit2(cs[2]), .chip_select_bit1(cs[1]),
    .chip_select_bit0(cs[0]), .four_contact(four_contact), .write_busy(write_busy));
  task automatic summarize;
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b);
    i2c_master_model_i.xfer(b, 1'b1, rx, k);
  endtask
  task automatic rd(input logic [7:0] exp, input logic last);
    i2c_master_model_i.xfer(8'hff, last, rx, k);
    check("read data", exp, rx);
  endtask
  task automatic begin_read;
    i2c_master_model_i.start();
    send({`DEV_TYPE_CODE, CS, 1'b1});
    check("read ack", 8'h01, {7'h0, k});
  endtask
  task automatic set_addr(input logic [15:0] a);
    i2c_master_model_i.start();
    send({`DEV_TYPE_CODE, CS, 1'b0});
    check("write ack", 8'h01, {7'h0, k});
    send(a[15:8]);
    check("addr hi ack", 8'h01, {7'h0, k});
    send(a[7:0]);
    check("addr lo ack", 8'h01, {7'h0, k});
  endtask
  // repeat the address byte until acknowledged, counting refusals
  task automatic poll;
    n = 0;
    do begin
      i2c_master_model_i.start();
      send({`DEV_TYPE_CODE, CS, 1'b0});
      i2c_master_model_i.stop();
      n += !k;
    end while (!k && n < 40);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1_000_000;
    fail_count++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    cs = CS;
    four_contact = 1'b0;
    rows[0] = {16'he000, 16'h0000, 8'h3c};
    rows[1] = {16'h1234, 16'h1234, 8'ha5};
    rows[2] = {16'h0021, 16'he021, 8'h00};
    rows[3] = {16'h1fff, 16'h1fff, 8'h81};
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      set_addr(rows[i].wa);
      send(rows[i].d);
      check("data ack", 8'h01, {7'h0, k});
      i2c_master_model_i.stop();
      poll();
      check("busy refusals", 8'h01, {7'h0, n != 0});
      check("poll ack", 8'h01, {7'h0, k});
      set_addr(rows[i].ra);
      begin_read();
      rd(rows[i].d, 1'b1);
      i2c_master_model_i.stop();
    end
    set_addr(16'h0100);
    begin_read();
    rd(8'hff, 1'b1);
    i2c_master_model_i.stop();
    set_addr(16'h1fff);
    begin_read();
    rd(8'h81, 1'b0);
    rd(8'h3c, 1'b1);
    i2c_master_model_i.stop();
    begin_read();
    rd(8'hff, 1'b1);
    i2c_master_model_i.stop();
    for (int j = 0; j < 4; j++) begin
      four_contact = j[1];
      i2c_master_model_i.start();
      send(j == 0 ? {4'h6, CS, 1'b0} : {`DEV_TYPE_CODE, j[0] ? 3'b000 : CS, 1'b0});
      check("select ack", {7'h0, j == 3}, {7'h0, k});
      i2c_master_model_i.stop();
    end
    four_contact = 1'b0;
    set_addr(16'h045e);
    for (int j = 0; j < 34; j++) begin
      send(8'h40 + 8'(j));
      check("page ack", 8'h01, {7'h0, k});
    end
    i2c_master_model_i.stop();
    poll();
    check("page refusals", 8'h01, {7'h0, n != 0});
    set_addr(16'h0440);
    begin_read();
    for (int j = 0; j < 32; j++) begin
      int m;
      m = (j + 2) % 32;
      if (m < 2) m += 32;
      rd(8'h40 + 8'(m), j == 31);
    end
    i2c_master_model_i.stop();
    set_addr(16'h0200);
    send(8'h77);
    i2c_master_model_i.stop();
    repeat (8) @(negedge clk);
    reset = 1'b1;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check("busy after reset", 8'h00, {7'h0, write_busy});
    check("oe after reset", 8'h00, {7'h0, sda_oe});
    poll();
    check("refusals after reset", 8'h00, 8'(n));
    summarize();
  end
endmodule
